// ---- common/vsio_params.svh ----
// Offsets, field positions, reset values and timing counts of the strap front end.
// Assumes a 20 MHz aclk and a 32-bit AXI4-Lite register bus.
`ifndef VSIO_PARAMS_SVH
`define VSIO_PARAMS_SVH
`define VSIO_CLK_HZ 20000000
`define VSIO_WIN_SIZE 16'h0800
`define VSIO_AM_SUPER 6'h2D
`define VSIO_AM_USER 6'h29
`define VSIO_OFF_STRAP 4'h0
`define VSIO_OFF_CTRL 4'h4
`define VSIO_OFF_STAT 4'h8
`define VSIO_CTRL_ID_LSB 0
`define VSIO_CTRL_OVR_BIT 3
`define VSIO_CTRL_DIAG_DONE 4
`define VSIO_CTRL_RESET 32'h00000000
`define VSIO_SCSI_RST_US 25
`define VSIO_SCSI_RST_CYC ((`VSIO_SCSI_RST_US*`VSIO_CLK_HZ+999999)/1000000)
`define VSIO_DIAG_S 15
`define VSIO_DIAG_CYC (`VSIO_DIAG_S*`VSIO_CLK_HZ)
`endif

// ---- common/vsio_pkg.sv ----
// Types shared by the strap front end.
// Constants live in vsio_params.svh.
package vsio_pkg;
  typedef struct packed {
    logic [15:0] addr;
    logic [5:0] am;
  } vsio_vme_s;
  typedef enum logic [1:0] {
    VSIO_ST_SAMPLE,
    VSIO_ST_RUN,
    VSIO_ST_DIAG,
    VSIO_ST_READY
  } vsio_phase_e;
  typedef struct packed {
    vsio_phase_e phase;
    logic [8:0] prim_sync1;
    logic [8:0] prim_sync2;
    logic [1:0] opt_sync1;
    logic [1:0] opt_sync2;
    logic [8:0] prim;
    logic [1:0] opt;
    logic [31:0] cnt;
    logic [31:0] rst_cnt;
    logic scsi_rst;
    logic sysfail;
    logic sel;
    logic [2:0] scsi_id;
    logic [2:0] host_id;
    logic id_ovr;
    logic diag_done;
    logic awdone;
    logic wdone;
    logic [15:0] awaddr;
    logic [31:0] wdata;
    logic bvalid;
    logic [1:0] bresp;
    logic arvalid_q;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } vsio_state_s;
endpackage

// ---- rtl/vsio_strap_decode.sv ----
// Strap decode and SYSFAIL sequencing of a VMEbus short I/O slave.
// Assumes switch pins are asynchronous, open pulls high, and AXI4-Lite
// master keeps valid and payload stable until taken.
//
// Local design decisions: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "vsio_params.svh"
module vsio_strap_decode #(
  parameter logic [31:0] DIAG_CYCLES = `VSIO_DIAG_CYC,
  parameter logic HAS_OPTION_BLOCK = 1'b1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic [8:0] primary_switch_block,
  input wire logic [1:0] option_switch_block,
  input wire vsio_pkg::vsio_vme_s vme_req,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic win_sel,
  output logic [2:0] scsi_id,
  output logic scsi_bus_reset,
  output logic sysfail_n
);
  localparam logic [31:0] RST_CYC = 32'(`VSIO_SCSI_RST_CYC);

  vsio_pkg::vsio_state_s st;
  vsio_pkg::vsio_state_s next_st;

  // Window hit from sampled straps and current VME address
  function automatic logic win_hit(input logic [8:0] sw,
                                   input vsio_pkg::vsio_vme_s rq);
    logic am_ok;
    am_ok = (rq.am == `VSIO_AM_SUPER) ||
            (sw[8] && rq.am == `VSIO_AM_USER);
    win_hit = am_ok && (rq.addr[15:11] == sw[7:3]);
  endfunction

  function automatic logic [31:0] rd_mux(input vsio_pkg::vsio_state_s s,
                                         input logic [3:0] a);
    case (a)
      `VSIO_OFF_STRAP: rd_mux = {21'h000000, s.opt, s.prim};
      `VSIO_OFF_CTRL: rd_mux = {27'h0000000, s.diag_done, s.id_ovr,
                                s.host_id};
      // Id kept whole so no field overlaps another
      `VSIO_OFF_STAT: rd_mux = {25'h0000000, s.phase, s.sysfail,
                                s.scsi_rst, s.scsi_id};
      default: rd_mux = 32'h00000000;
    endcase
  endfunction

  always_comb
  begin
    next_st = st;
    // Two flops before any logic reads the pins
    next_st.prim_sync1 = primary_switch_block;
    next_st.prim_sync2 = st.prim_sync1;
    next_st.opt_sync1 = option_switch_block;
    next_st.opt_sync2 = st.opt_sync1;
    // Pins read as-is: open pulls high, so open gives 1
    case (st.phase)
      vsio_pkg::VSIO_ST_SAMPLE:
      begin
        // Waits for synchroniser to fill after release
        if (st.cnt == 32'h00000002)
        begin
          next_st.prim = st.prim_sync2;
          next_st.opt = HAS_OPTION_BLOCK ? st.opt_sync2 : 2'h0;
          next_st.scsi_rst = !HAS_OPTION_BLOCK || !st.opt_sync2[0];
          next_st.rst_cnt = 32'h00000000;
          next_st.cnt = 32'h00000000;
          next_st.phase = vsio_pkg::VSIO_ST_RUN;
        end
        else
        begin
          next_st.cnt = st.cnt + 32'h00000001;
        end
      end
      vsio_pkg::VSIO_ST_RUN:
      begin
        if (!HAS_OPTION_BLOCK || st.opt[1])
        begin
          next_st.phase = HAS_OPTION_BLOCK ? vsio_pkg::VSIO_ST_DIAG
                                           : vsio_pkg::VSIO_ST_READY;
          next_st.sysfail = HAS_OPTION_BLOCK;
        end
        else
        begin
          next_st.sysfail = 1'b0;
          next_st.phase = vsio_pkg::VSIO_ST_READY;
        end
      end
      vsio_pkg::VSIO_ST_DIAG:
      begin
        // Diagnostics end on timeout or on firmware completion flag
        next_st.cnt = st.cnt + 32'h00000001;
        if (st.cnt >= DIAG_CYCLES - 32'h00000001 || st.diag_done)
        begin
          next_st.sysfail = 1'b0;
          next_st.phase = vsio_pkg::VSIO_ST_READY;
        end
      end
      vsio_pkg::VSIO_ST_READY:
      begin
        next_st.sysfail = 1'b0;
      end
      default:
      begin
        next_st.phase = vsio_pkg::VSIO_ST_SAMPLE;
      end
    endcase
    // Fixed-width SCSI reset pulse after sampling
    if (st.scsi_rst)
    begin
      next_st.rst_cnt = st.rst_cnt + 32'h00000001;
      if (st.rst_cnt >= RST_CYC - 32'h00000001)
      begin
        next_st.scsi_rst = 1'b0;
      end
    end
    next_st.sel = (st.phase != vsio_pkg::VSIO_ST_SAMPLE) &&
                  win_hit(st.prim, vme_req);
    next_st.scsi_id = st.id_ovr ? st.host_id : st.prim[2:0];
    // Write channel: address and data in either order
    if (s_axi_awvalid && !st.awdone)
    begin
      next_st.awdone = 1'b1;
      next_st.awaddr = {12'h000, s_axi_awaddr};
    end
    if (s_axi_wvalid && !st.wdone)
    begin
      next_st.wdone = 1'b1;
      next_st.wdata = s_axi_wdata;
    end
    if (st.awdone && st.wdone && !st.bvalid)
    begin
      next_st.bvalid = 1'b1;
      next_st.bresp = 2'h0;
      if (st.awaddr[3:0] == `VSIO_OFF_CTRL)
      begin
        if (s_axi_wstrb[0])
        begin
          next_st.host_id = st.wdata[`VSIO_CTRL_ID_LSB +: 3];
          next_st.id_ovr = st.wdata[`VSIO_CTRL_OVR_BIT];
          next_st.diag_done = st.wdata[`VSIO_CTRL_DIAG_DONE];
        end
      end
      else if (st.awaddr[3:0] != `VSIO_OFF_STRAP &&
               st.awaddr[3:0] != `VSIO_OFF_STAT)
      begin
        next_st.bresp = 2'h2;
      end
    end
    if (st.bvalid && s_axi_bready)
    begin
      next_st.bvalid = 1'b0;
      next_st.awdone = 1'b0;
      next_st.wdone = 1'b0;
    end
    // Read channel
    next_st.arvalid_q = 1'b0;
    if (s_axi_arvalid && !st.rvalid && !st.arvalid_q)
    begin
      next_st.arvalid_q = 1'b1;
      next_st.rvalid = 1'b1;
      next_st.rdata = rd_mux(st, s_axi_araddr);
      next_st.rresp = (s_axi_araddr == `VSIO_OFF_STRAP ||
                       s_axi_araddr == `VSIO_OFF_CTRL ||
                       s_axi_araddr == `VSIO_OFF_STAT) ? 2'h0 : 2'h2;
    end
    if (st.rvalid && s_axi_rready)
    begin
      next_st.rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st <= '0;
      st.sysfail <= 1'b1;
    end
    else if (clk_en)
    begin
      st <= next_st;
    end
  end

  always_comb
  begin
    s_axi_awready = !st.awdone;
    s_axi_wready = !st.wdone;
  end
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = st.arvalid_q;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;
  assign win_sel = st.sel;
  assign scsi_id = st.scsi_id;
  assign scsi_bus_reset = st.scsi_rst;
  assign sysfail_n = !st.sysfail;

  // Straps frozen once sampled
  strap_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && st.phase != vsio_pkg::VSIO_ST_SAMPLE |=>
    $stable(st.prim)) else $error("straps changed after sampling");
  id_select_a: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en |=> scsi_id == ($past(st.id_ovr) ? $past(st.host_id)
    : $past(st.prim[2:0]))) else $error("scsi id wrong");
  am_filter_a: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && !st.prim[8] && vme_req.am == `VSIO_AM_USER |=>
    !win_sel) else $error("user modifier accepted");
  addr_match_a: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && win_sel |-> $past(vme_req.addr[15:11]) == st.prim[7:3])
    else $error("window hit on wrong base");
  fast_release_a: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && st.phase == vsio_pkg::VSIO_ST_RUN && HAS_OPTION_BLOCK &&
    !st.opt[1] |=> sysfail_n) else $error("sysfail held");
  diag_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    st.phase == vsio_pkg::VSIO_ST_DIAG |-> !sysfail_n)
    else $error("sysfail released in diag");
  rst_pulse_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(scsi_bus_reset) |-> !HAS_OPTION_BLOCK || !st.opt[0])
    else $error("unwanted scsi reset");
  always_rst_a: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && !HAS_OPTION_BLOCK && st.phase == vsio_pkg::VSIO_ST_SAMPLE
    && st.cnt == 32'h00000002 |=> scsi_bus_reset)
    else $error("no reset without option block");
  no_diag_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !HAS_OPTION_BLOCK |-> st.phase != vsio_pkg::VSIO_ST_DIAG)
    else $error("diag without option block");

  // Decode is dead until the straps are sampled
  sel_gated_a: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && st.phase == vsio_pkg::VSIO_ST_SAMPLE |=>
    !win_sel)
    else $error("window selected before sampling");

  opt_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && st.phase != vsio_pkg::VSIO_ST_SAMPLE |=>
    $stable(st.opt))
    else $error("option straps changed");

  addr_miss_a: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && vme_req.addr[15:11] != st.prim[7:3] |=>
    !win_sel)
    else $error("window hit outside base");

  super_accept_a: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && st.phase != vsio_pkg::VSIO_ST_SAMPLE &&
    vme_req.am == `VSIO_AM_SUPER &&
    vme_req.addr[15:11] == st.prim[7:3] |=> win_sel)
    else $error("supervisor access missed");

  user_accept_a: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && st.phase != vsio_pkg::VSIO_ST_SAMPLE && st.prim[8] &&
    vme_req.am == `VSIO_AM_USER &&
    vme_req.addr[15:11] == st.prim[7:3] |=> win_sel)
    else $error("user access missed");

  // Identifier source follows the override flag
  sw_apply_a: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && !st.id_ovr |=>
    scsi_id == $past(st.prim[2:0]))
    else $error("switch id not used");

  ovr_apply_a: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && st.id_ovr |=>
    scsi_id == $past(st.host_id))
    else $error("host id not used");

  host_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && st.awdone && st.wdone && !st.bvalid &&
    st.awaddr[3:0] == `VSIO_OFF_CTRL && s_axi_wstrb[0] |=>
    st.host_id == $past(st.wdata[2:0]))
    else $error("host id not stored");

  // Pulse width bounded by its own counter
  rst_width_a: assert property (@(posedge aclk) disable iff (!aresetn)
    scsi_bus_reset |-> st.rst_cnt < RST_CYC)
    else $error("scsi reset too long");

  rst_end_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(scsi_bus_reset) |->
    $past(st.rst_cnt) == RST_CYC - 32'h00000001)
    else $error("scsi reset too short");

  no_rst_a: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && HAS_OPTION_BLOCK && st.phase == vsio_pkg::VSIO_ST_SAMPLE
    && st.cnt == 32'h00000002 && st.opt_sync2[0] |=>
    !scsi_bus_reset)
    else $error("scsi reset with switch open");

  diag_entry_a: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && HAS_OPTION_BLOCK && st.phase == vsio_pkg::VSIO_ST_RUN &&
    st.opt[1] |=> st.phase == vsio_pkg::VSIO_ST_DIAG && !sysfail_n)
    else $error("diagnostics skipped");

  diag_bound_a: assert property (@(posedge aclk) disable iff (!aresetn)
    st.phase == vsio_pkg::VSIO_ST_DIAG |-> st.cnt < DIAG_CYCLES)
    else $error("diagnostics overran");

  ready_free_a: assert property (@(posedge aclk) disable iff (!aresetn)
    st.phase == vsio_pkg::VSIO_ST_READY |-> sysfail_n)
    else $error("sysfail held when ready");

  rst_cov: cover property (@(posedge aclk) disable iff (!aresetn)
    $fell(scsi_bus_reset));
  user_cov: cover property (@(posedge aclk) disable iff (!aresetn)
    win_sel && $past(vme_req.am) == `VSIO_AM_USER);
  win_cov: cover property (@(posedge aclk) disable iff (!aresetn)
    win_sel);
  ovr_cov: cover property (@(posedge aclk) disable iff (!aresetn)
    st.id_ovr && scsi_id == st.host_id);
  diag_cov: cover property (@(posedge aclk) disable iff (!aresetn)
    st.phase == vsio_pkg::VSIO_ST_DIAG ##1
    st.phase == vsio_pkg::VSIO_ST_READY);
endmodule // vsio_strap_decode

// ---- tb/tb_vsio_strap_decode.sv ----
// Self-checking bench of the strap decode front end.
// Assumes vsio_host_model on the VME side; the bench is AXI master.
`timescale 1ns/10ps
`include "vsio_params.svh"
module tb_vsio_strap_decode;
  // Short diagnostic count keeps each reset round brief
  localparam logic [31:0] DIAG = 32'h32;
  logic aclk, aresetn, clk_en, go;
  logic [8:0] prim, pv;
  logic [1:0] opt, ov, resp, bresp, rresp;
  logic [15:0] addr, a;
  logic [5:0] am, m;
  logic [3:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic win_sel, scsi_bus_reset, sysfail_n;
  logic [2:0] scsi_id, h;
  vsio_pkg::vsio_vme_s vme_req;
  logic rst_nob, sf_nob_n;
  int failures, num_checks, rs, sf, rs2, sf2, i, j, k;

  vsio_host_model vsio_host_model_i (
    .aclk(aclk),
    .go(go),
    .addr(addr),
    .am(am),
    .vme_req(vme_req)
  );

  vsio_strap_decode #(
    .DIAG_CYCLES(DIAG),
    .HAS_OPTION_BLOCK(1'b1)
  ) vsio_strap_decode_i (
    .aclk(aclk),
    .aresetn(aresetn),
    .clk_en(clk_en),
    .primary_switch_block(prim),
    .option_switch_block(opt),
    .vme_req(vme_req),
    .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid),
    .s_axi_awready(awready),
    .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid),
    .s_axi_wready(wready),
    .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid),
    .s_axi_bready(bready),
    .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid),
    .s_axi_arready(arready),
    .s_axi_rdata(rdata),
    .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid),
    .s_axi_rready(rready),
    .win_sel(win_sel),
    .scsi_id(scsi_id),
    .scsi_bus_reset(scsi_bus_reset),
    .sysfail_n(sysfail_n)
  );

  // Variant without the option block, watched for its fixed behaviour
  vsio_strap_decode #(
    .DIAG_CYCLES(DIAG),
    .HAS_OPTION_BLOCK(1'b0)
  ) vsio_strap_decode_nob_i (
    .aclk(aclk),
    .aresetn(aresetn),
    .clk_en(clk_en),
    .primary_switch_block(prim),
    .option_switch_block(opt),
    .vme_req(vme_req),
    .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid),
    .s_axi_awready(),
    .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid),
    .s_axi_wready(),
    .s_axi_bresp(),
    .s_axi_bvalid(),
    .s_axi_bready(bready),
    .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid),
    .s_axi_arready(),
    .s_axi_rdata(),
    .s_axi_rresp(),
    .s_axi_rvalid(),
    .s_axi_rready(rready),
    .win_sel(),
    .scsi_id(),
    .scsi_bus_reset(rst_nob),
    .sysfail_n(sf_nob_n)
  );

  initial
  begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  function automatic logic hit(input logic [15:0] ha, input logic [5:0] hm);
    return ha[15:11] == pv[7:3] && (hm == `VSIO_AM_SUPER ||
      (pv[8] && hm == `VSIO_AM_USER));
  endfunction

  task automatic chk(input string nm, input logic [31:0] g,
    input logic [31:0] e);
    num_checks++;
    if (g !== e)
    begin
      failures++;
      $display("unexpected %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic tmo(input logic ok);
    chk("handshake", ok, 1'b1);
    if (!ok)
      finish_test();
  endtask

  task automatic wr(input logic [3:0] wa, input logic [31:0] wd);
    k = 0;
    awaddr <= wa;
    wdata <= wd;
    {awvalid, wvalid, bready} <= 3'h7;
    do
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      k++;
    end
    while (bvalid !== 1'b1 && k < 50);
    resp = bresp;
    bready <= 1'b0;
    tmo(bvalid === 1'b1);
  endtask

  task automatic rd(input logic [3:0] ra);
    k = 0;
    // Lets rready drop for a cycle between reads
    @(posedge aclk);
    araddr <= ra;
    {arvalid, rready} <= 2'h3;
    do
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      k++;
    end
    while (rvalid !== 1'b1 && k < 50);
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
    tmo(rvalid === 1'b1);
  endtask

  task automatic probe(input logic [15:0] pa, input logic [5:0] pm,
    input logic e);
    go <= 1'b1;
    addr <= pa;
    am <= pm;
    repeat (3) @(posedge aclk);
    chk("win_sel", win_sel, e);
    go <= 1'b0;
    @(posedge aclk);
  endtask

  initial
  begin
    {aresetn, go, addr, am, prim, opt, awaddr, awvalid, wdata} = '0;
    {wvalid, bready, araddr, arvalid, rready, failures, num_checks} = '0;
    clk_en = 1'b1;
    void'($urandom(32'h5DC271FD));
    for (i = 0; i < 4; i++)
    begin
      aresetn <= 1'b0;
      prim <= 9'($urandom());
      opt <= 2'(i);
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      pv = prim;
      ov = opt;
      {rs, sf, rs2, sf2} = '0;
      for (j = 0; j < 700; j++)
      begin
        @(posedge aclk);
        rs += int'(scsi_bus_reset === 1'b1);
        if (sysfail_n !== 1'b1) sf = j + 1;
        rs2 += int'(rst_nob === 1'b1);
        if (sf_nob_n !== 1'b1) sf2 = j + 1;
      end
      chk("rst_len0", rs2, `VSIO_SCSI_RST_CYC);
      chk("diag0", sf2 >= DIAG, 1'b0);
      chk("rst_len", rs, ov[0] ? 0 : `VSIO_SCSI_RST_CYC);
      chk("diag", sf >= DIAG, ov[1]);
      chk("sysfail_n", sysfail_n, 1'b1);
      chk("scsi_id", scsi_id, pv[2:0]);
      for (j = 0; j < 12; j++)
      begin
        a = 16'($urandom());
        if (j[0]) a[15:11] = pv[7:3];
        if (j < 4) a[10:0] = j[1] ? 11'h7FF : 11'h000;
        if (j == 2) a = {pv[7:3], 11'h000} - 16'h0001;
        m = 6'($urandom());
        if (j % 3 == 0) m = `VSIO_AM_SUPER;
        if (j % 3 == 1) m = `VSIO_AM_USER;
        probe(a, m, hit(a, m));
      end
      // Flipped switches must not reach decode before next reset
      prim <= ~pv;
      opt <= ~ov;
      repeat (8) @(posedge aclk);
      chk("held_id", scsi_id, pv[2:0]);
      probe({pv[7:3], 11'h400}, `VSIO_AM_SUPER, 1'b1);
    end
    for (i = 0; i < 3; i++)
    begin
      h = 3'($urandom());
      wr(`VSIO_OFF_CTRL, {28'h0, 1'b1, h});
      chk("bresp", resp, 2'h0);
      repeat (2) @(posedge aclk);
      chk("ovr_id", scsi_id, h);
      rd(`VSIO_OFF_CTRL);
      chk("ctrl", d[3:0], {1'b1, h});
      wr(`VSIO_OFF_CTRL, 32'h0);
      repeat (2) @(posedge aclk);
      chk("sw_id", scsi_id, pv[2:0]);
    end
    rd(`VSIO_OFF_STRAP);
    chk("strap", d[10:0], {ov, pv});
    rd(4'hC);
    chk("rresp", resp, 2'h2);
    wr(4'hC, 32'h0);
    chk("bresp", resp, 2'h2);
    finish_test();
  end
endmodule // tb_vsio_strap_decode

// ---- tb/vsio_host_model.sv ----
// Behavioural VME host driving the short I/O request lines.
// Assumes the bench commands each cycle's address and modifier.
`timescale 1ns/10ps
module vsio_host_model (
  input wire logic aclk,
  input wire logic go,
  input wire logic [15:0] addr,
  input wire logic [5:0] am,
  output vsio_pkg::vsio_vme_s vme_req
);
  initial vme_req = '0;
  // Idle lines invert each cycle so no stale request lingers
  always @(posedge aclk)
    vme_req <= go ? {addr, am} : ~vme_req;
endmodule // vsio_host_model
